// File: design/sdn_decode.sv
module sdn_decode #(
	parameter int COR_DEPTH = 16,
	parameter int DISP_DEPTH = 256
) (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic ce,
	input wire logic [sdn_pkg::SDN_ADDR_W-1:0] reg_addr,
	input wire logic [sdn_pkg::SDN_DATA_W-1:0] reg_wdata,
	input wire logic reg_we,
	input wire logic reg_re,
	output logic [sdn_pkg::SDN_DATA_W-1:0] reg_rdata,
	input wire logic [sdn_pkg::SDN_WORD_W-1:0] prog_word_hi,
	input wire logic [sdn_pkg::SDN_WORD_W-1:0] prog_word_lo,
	input wire logic [sdn_pkg::SDN_POS_W-1:0] bit_pos,
	input wire logic syl_valid,
	input wire logic [3:0] env_present,
	output logic syl_ready,
	output sdn_pkg::sdn_syl_s syl_o,
	output logic syl_valid_o,
	output logic lit_vs_push,
	output logic lit_ns_push,
	output sdn_pkg::sdn_name_s name_o,
	output logic au_valid,
	output logic [5:0] au_op,
	output logic env_fault,
	output logic [31:0] term_ref,
	output logic term_valid,
	input wire logic [sdn_pkg::SDN_WORD_W-1:0] desc_word,
	input wire logic desc_valid,
	output sdn_pkg::sdn_desc_s desc_o,
	output logic desc_valid_o,
	output logic [2:0] fmt_eff,
	output sdn_pkg::sdn_name_s rd_fault_name,
	output sdn_pkg::sdn_name_s wr_fault_name,
	output sdn_pkg::sdn_name_s call_name,
	input wire logic fetch_l1,
	input wire logic store_l1,
	output logic rd_fault_call,
	output logic wr_fault_call,
	output logic alloc_fault,
	output logic invalid_field
);
	import sdn_pkg::*;

	function automatic sdn_name_s name_dec(input logic [27:0] f);
		sdn_name_s n;
		n = '0;
		n.ntype = f[27:24];
		n.len = 5'd4;
		case (f[27:24])
			SDN_NT_COR88: begin
				n.coroutine_index = f[23:20];
				n.lexical_depth = f[19:12];
				n.disp = {8'h00, f[11:4]};
				n.len = 5'd24;
			end
			SDN_NT_COR412: begin
				n.coroutine_index = f[23:20];
				n.lexical_depth = {4'h0, f[19:16]};
				n.disp = {4'h0, f[15:4]};
				n.len = 5'd24;
			end
			SDN_NT_DSP88: begin
				n.lexical_depth = f[23:16];
				n.disp = {8'h00, f[15:8]};
				n.len = 5'd20;
			end
			SDN_NT_DSP412: begin
				n.lexical_depth = {4'h0, f[23:20]};
				n.disp = {4'h0, f[19:8]};
				n.len = 5'd20;
			end
			SDN_NT_SLC8, SDN_NT_PRG8, SDN_NT_NB8: begin
				n.disp = {8'h00, f[23:16]};
				n.len = 5'd12;
			end
			SDN_NT_SLC12: begin
				n.disp = {4'h0, f[23:12]};
				n.len = 5'd16;
			end
			SDN_NT_PRG16, SDN_NT_NB16: begin
				n.disp = f[23:8];
				n.len = 5'd20;
			end
			SDN_NT_CNB8: begin
				n.coroutine_index = f[23:20];
				n.disp = {8'h00, f[19:12]};
				n.len = 5'd16;
			end
			SDN_NT_CNB16: begin
				n.coroutine_index = f[23:20];
				n.disp = f[19:4];
				n.len = 5'd24;
			end
			SDN_NT_TOP: n.len = 5'd4;
			default: n.invalid = 1'b1;
		endcase
		return n;
	endfunction

	function automatic logic [6:0] quad_width(input logic [1:0] code, input logic doubling);
		logic [6:0] w;
		w = doubling ? (7'd4 << code) : ({5'h00, code} + 7'd1) << 2;
		return w;
	endfunction

	logic [SDN_DATA_W-1:0] ctrl_q, disp_base_q, slice_base_q, prog_base_q, nbase_q, top_entry_q, tbl_addr_q;
	logic [2:0] sticky_q;
	logic [SDN_DATA_W-1:0] cor_tbl [COR_DEPTH];
	logic [SDN_DATA_W-1:0] disp_tbl [DISP_DEPTH];
	sdn_walk_e st_q, st_d;
	sdn_name_s nm_q;
	logic [31:0] base_q, base_d, term_d;
	logic rflag_q, wflag_q;
	logic [2:0] last_fmt_q;

	wire logic [127:0] pair = {prog_word_hi, prog_word_lo};
	wire logic [127:0] shifted = pair << bit_pos;
	wire logic [63:0] aligned = shifted[127:64];
	wire logic [7:0] opc = aligned[63:56];
	wire logic [1:0] cls = opc[7:6];
	wire logic [6:0] lit_len = quad_width(opc[5:4], 1'b1);
	wire logic [63:0] lit_sh = (aligned << SDN_LITHDR_W) >> (7'd64 - lit_len);
	wire sdn_name_s op_name = name_dec(aligned[55:28]);
	wire logic top_slice = (cls == SDN_CLS_NAME) && opc[0];
	wire logic take = syl_valid && syl_ready && ctrl_q[0];
	wire logic env_ok = env_present[cls];
	wire logic issue = take && env_ok;
	wire logic name_go = issue && (cls == SDN_CLS_NAME);
	wire logic name_bad = name_go && !top_slice && op_name.invalid;

	sdn_syl_s syl_d;
	always_comb begin
		syl_d = '0;
		syl_d.opcode = opc;
		syl_d.cls = cls;
		syl_d.op_field = (cls == SDN_CLS_NAME) ? {1'b0, opc[5:1]} : opc[5:0];
		syl_d.top_slice = top_slice;
		if (cls == SDN_CLS_LIT) begin
			syl_d.lit_len = lit_len[5:0];
			syl_d.lit_dest = aligned[55];
			syl_d.lit_fmt = aligned[54:52];
			syl_d.literal = lit_sh[31:0];
		end
		if (top_slice) begin
			syl_d.literal = {24'h000000, aligned[55:48]};
		end
	end

	// lookup walk: only coroutine and display names need table reads
	wire logic [7:0] disp_idx = 8'(base_q + 32'(nm_q.lexical_depth));
	wire logic [31:0] slice_entry = disp_tbl[disp_idx];
	wire logic [31:0] cor_entry = cor_tbl[nm_q.coroutine_index];
	wire logic [31:0] op_disp = 32'(op_name.disp);

	always_comb begin
		st_d = st_q;
		base_d = base_q;
		term_d = term_ref;
		case (st_q)
			SDN_IDLE: begin
				if (name_go && top_slice) begin
					term_d = slice_base_q + {24'h000000, aligned[55:48]};
					st_d = SDN_DONE;
				end else if (name_go && !name_bad) begin
					case (op_name.ntype)
						SDN_NT_COR88, SDN_NT_COR412, SDN_NT_CNB8, SDN_NT_CNB16: st_d = SDN_COR;
						SDN_NT_DSP88, SDN_NT_DSP412: begin
							base_d = disp_base_q;
							st_d = SDN_DISP;
						end
						SDN_NT_SLC8, SDN_NT_SLC12: begin
							term_d = slice_base_q + op_disp;
							st_d = SDN_DONE;
						end
						SDN_NT_PRG8, SDN_NT_PRG16: begin
							term_d = prog_base_q + op_disp;
							st_d = SDN_DONE;
						end
						SDN_NT_NB8, SDN_NT_NB16: begin
							term_d = nbase_q + op_disp;
							st_d = SDN_DONE;
						end
						default: begin
							term_d = top_entry_q;
							st_d = SDN_DONE;
						end
					endcase
				end
			end
			SDN_COR: begin
				base_d = cor_entry;
				if (nm_q.ntype == SDN_NT_CNB8 || nm_q.ntype == SDN_NT_CNB16) begin
					term_d = cor_entry + 32'(nm_q.disp);
					st_d = SDN_DONE;
				end else begin
					st_d = SDN_DISP;
				end
			end
			SDN_DISP: begin
				term_d = slice_entry + 32'(nm_q.disp);
				st_d = SDN_DONE;
			end
			SDN_DONE: st_d = SDN_IDLE;
			default: st_d = SDN_IDLE;
		endcase
	end

	// descriptor split; each stage shifts away what the previous consumed
	wire logic [63:0] d = desc_word;
	wire logic [1:0] obj = d[61:60];
	wire logic [6:0] link_w = quad_width(d[57:56], 1'b0);
	wire logic [63:0] link_sh = (d << SDN_IA_DATA_W) >> (7'd64 - link_w);
	wire logic [6:0] ia_w = (obj == SDN_OBJ_DESC) ? SDN_IA_DESC_W :
		(obj == SDN_OBJ_PROG) ? SDN_IA_DATA_W + link_w : SDN_IA_DATA_W;
	wire logic [63:0] r1 = d << ia_w;
	wire sdn_name_s rdn = name_dec(r1[63:36]);
	wire logic [63:0] r2 = d[63] ? (r1 << rdn.len) : r1;
	wire sdn_name_s wrn = name_dec(r2[63:36]);
	wire logic [63:0] r3 = d[62] ? (r2 << wrn.len) : r2;
	wire logic [3:0] se_type = r3[59:56];
	wire sdn_name_s cln = name_dec(r3[55:28]);
	wire logic [6:0] pw = quad_width(r3[62:61], 1'b0) + {4'h0, r3[63], 2'h0};
	wire logic [63:0] gen_sh = (r3 << SDN_SEHDR_W) >> (7'd64 - pw);
	wire logic desc_bad = (d[63] && rdn.invalid) || (d[62] && wrn.invalid) ||
		(se_type == SDN_SE_CALL && cln.invalid);
	wire logic is_data = (obj == SDN_OBJ_DATA) || (obj == SDN_OBJ_LOCK);
	wire logic dtake = desc_valid && ctrl_q[0];

	sdn_desc_s desc_d;
	always_comb begin
		desc_d = '0;
		desc_d.rd_flt = d[63];
		desc_d.wr_flt = d[62];
		desc_d.obj = obj;
		if (is_data) begin
			desc_d.value_stack_resident_flag = d[59];
			desc_d.fmt_sel = d[58:56];
		end
		if (obj == SDN_OBJ_PROG) begin
			desc_d.params_present = d[59];
			desc_d.result_returned = d[58];
			desc_d.display_ctl_word_idx = link_sh[15:0];
		end
		desc_d.param_width_code = r3[63:61];
		desc_d.alloc = r3[60];
		desc_d.se_type = se_type;
		desc_d.end_delimiter = (se_type == SDN_SE_FIN);
		if (se_type == SDN_SE_SEG) begin
			desc_d.se_param = {8'h00, r3[55:48]};
		end else if (se_type != SDN_SE_CALL) begin
			desc_d.se_param = gen_sh[15:0];
		end
	end

	wire logic [2:0] fmt_d = (is_data && d[58:56] == 3'h0) ? last_fmt_q : d[58:56];
	wire logic alloc_d = dtake && !r3[60];
	wire logic inval_d = name_bad || (dtake && desc_bad);
	wire logic [2:0] sticky_set = {inval_d, alloc_d, take && !env_ok};
	wire logic st_wr = reg_we && reg_addr == SDN_R_STATUS;
	wire logic [2:0] sticky_d = (sticky_q & ~(st_wr ? reg_wdata[2:0] : 3'h0)) | sticky_set;

	logic [SDN_DATA_W-1:0] rd_mux;
	always_comb begin
		if (reg_addr == SDN_R_CTRL) begin
			rd_mux = ctrl_q;
		end else if (reg_addr == SDN_R_DISP_BASE) begin
			rd_mux = disp_base_q;
		end else if (reg_addr == SDN_R_SLICE_BASE) begin
			rd_mux = slice_base_q;
		end else if (reg_addr == SDN_R_PROG_BASE) begin
			rd_mux = prog_base_q;
		end else if (reg_addr == SDN_R_NBASE) begin
			rd_mux = nbase_q;
		end else if (reg_addr == SDN_R_TOP_ENTRY) begin
			rd_mux = top_entry_q;
		end else if (reg_addr == SDN_R_STATUS) begin
			rd_mux = {28'h0000000, st_q != SDN_IDLE, sticky_q};
		end else if (reg_addr == SDN_R_TERM_REF) begin
			rd_mux = term_ref;
		end else if (reg_addr == SDN_R_TBL_ADDR) begin
			rd_mux = tbl_addr_q;
		end else if (reg_addr == SDN_R_COR_DATA) begin
			rd_mux = cor_tbl[tbl_addr_q[$clog2(COR_DEPTH)-1:0]];
		end else if (reg_addr == SDN_R_DISP_DATA) begin
			rd_mux = disp_tbl[tbl_addr_q[$clog2(DISP_DEPTH)-1:0]];
		end else begin
			rd_mux = '0;
		end
	end

	// tables carry no reset; names are enabled from reset, so software loads them before issuing names that walk them
	always_ff @(posedge clk_sys) begin
		if (ce && reg_we && reg_addr == SDN_R_COR_DATA) begin
			cor_tbl[tbl_addr_q[$clog2(COR_DEPTH)-1:0]] <= reg_wdata;
		end
		if (ce && reg_we && reg_addr == SDN_R_DISP_DATA) begin
			disp_tbl[tbl_addr_q[$clog2(DISP_DEPTH)-1:0]] <= reg_wdata;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			ctrl_q <= SDN_CTRL_RST;
			disp_base_q <= '0;
			slice_base_q <= '0;
			prog_base_q <= '0;
			nbase_q <= '0;
			top_entry_q <= '0;
			tbl_addr_q <= '0;
			reg_rdata <= '0;
			sticky_q <= '0;
		end else if (ce) begin
			if (reg_we && reg_addr == SDN_R_CTRL) ctrl_q <= reg_wdata;
			if (reg_we && reg_addr == SDN_R_DISP_BASE) disp_base_q <= reg_wdata;
			if (reg_we && reg_addr == SDN_R_SLICE_BASE) slice_base_q <= reg_wdata;
			if (reg_we && reg_addr == SDN_R_PROG_BASE) prog_base_q <= reg_wdata;
			if (reg_we && reg_addr == SDN_R_NBASE) nbase_q <= reg_wdata;
			if (reg_we && reg_addr == SDN_R_TOP_ENTRY) top_entry_q <= reg_wdata;
			if (reg_we && reg_addr == SDN_R_TBL_ADDR) tbl_addr_q <= reg_wdata;
			reg_rdata <= reg_re ? rd_mux : '0;
			sticky_q <= sticky_d;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			st_q <= SDN_IDLE;
			nm_q <= '0;
			base_q <= '0;
			term_ref <= '0;
			term_valid <= 1'b0;
			syl_ready <= 1'b0;
			syl_o <= '0;
			syl_valid_o <= 1'b0;
			lit_vs_push <= 1'b0;
			lit_ns_push <= 1'b0;
			name_o <= '0;
			au_valid <= 1'b0;
			au_op <= '0;
			env_fault <= 1'b0;
		end else if (ce) begin
			st_q <= st_d;
			base_q <= base_d;
			term_ref <= term_d;
			term_valid <= (st_d == SDN_DONE);
			syl_ready <= (st_d == SDN_IDLE);
			if (name_go) nm_q <= op_name;
			if (issue) syl_o <= syl_d;
			syl_valid_o <= issue;
			lit_vs_push <= issue && cls == SDN_CLS_LIT && !aligned[55];
			lit_ns_push <= issue && cls == SDN_CLS_LIT && aligned[55];
			if (name_go && !top_slice) name_o <= op_name;
			au_valid <= issue && cls == SDN_CLS_AU;
			if (issue && cls == SDN_CLS_AU) au_op <= opc[5:0];
			env_fault <= take && !env_ok;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			desc_o <= '0;
			desc_valid_o <= 1'b0;
			fmt_eff <= SDN_FMT_RST;
			last_fmt_q <= SDN_FMT_RST;
			rflag_q <= 1'b0;
			wflag_q <= 1'b0;
			rd_fault_name <= '0;
			wr_fault_name <= '0;
			call_name <= '0;
			rd_fault_call <= 1'b0;
			wr_fault_call <= 1'b0;
			alloc_fault <= 1'b0;
			invalid_field <= 1'b0;
		end else if (ce) begin
			desc_valid_o <= dtake && r3[60];
			if (dtake) begin
				desc_o <= desc_d;
				fmt_eff <= fmt_d;
				if (is_data && d[58:56] != 3'h0) last_fmt_q <= d[58:56];
				rflag_q <= d[63];
				wflag_q <= d[62];
				rd_fault_name <= d[63] ? rdn : '0;
				wr_fault_name <= d[62] ? wrn : '0;
				call_name <= (se_type == SDN_SE_CALL) ? cln : '0;
			end
			rd_fault_call <= fetch_l1 && rflag_q;
			wr_fault_call <= store_l1 && wflag_q;
			alloc_fault <= alloc_d;
			invalid_field <= inval_d;
		end
	end

	sequence s_cor_name;
		ce && name_go && !top_slice && op_name.ntype == SDN_NT_COR88;
	endsequence
	a_au_handoff: assert property (@(posedge clk_sys) disable iff (rst)
		ce && issue && cls == SDN_CLS_AU |=> au_valid && au_op == $past(opc[5:0]))
		else $error("au handoff missing");
	a_env_block: assert property (@(posedge clk_sys) disable iff (rst)
		ce && take && !env_ok |=> env_fault && !au_valid && !syl_valid_o)
		else $error("syllable issued without environment");
	a_opcode_iso: assert property (@(posedge clk_sys) disable iff (rst)
		ce && issue |=> syl_o.opcode == $past(aligned[63:56]))
		else $error("opcode not isolated");
	a_cor_walk: assert property (@(posedge clk_sys) disable iff (rst)
		s_cor_name |-> ##[3:8] term_valid)
		else $error("coroutine walk too slow");
	a_alloc_fault: assert property (@(posedge clk_sys) disable iff (rst)
		ce && dtake && !r3[60] |=> alloc_fault && !desc_valid_o)
		else $error("allocate fault missing");
	a_read_fault: assert property (@(posedge clk_sys) disable iff (rst)
		ce && fetch_l1 |=> rd_fault_call == $past(rflag_q))
		else $error("read fault call wrong");
	a_write_fault: assert property (@(posedge clk_sys) disable iff (rst)
		ce && store_l1 |=> wr_fault_call == $past(wflag_q))
		else $error("write fault call wrong");
	a_fmt_default: assert property (@(posedge clk_sys) disable iff (rst)
		ce && dtake && is_data && d[58:56] == 3'h0 |=> fmt_eff == $past(last_fmt_q))
		else $error("default format not used");
	a_bad_name: assert property (@(posedge clk_sys) disable iff (rst)
		ce && name_bad |=> invalid_field && !term_valid ##1 !term_valid)
		else $error("invalid name not flagged");
endmodule // sdn_decode

// File: shared/sdn_pkg.sv
package sdn_pkg;
// How it works
// - two adjacent 64-bit buffer words are shifted so the current bit position leads
// - the eight leading aligned bits form the operation code
// - literals and names of variable length are cut out; a literal goes to the value stack or the name stack by its destination bit
// - operator class, literal size and the name or general operation are decoded
// - a name operator's name is walked into a terminal reference before completion
// - arithmetic-class operation field is handed to the arithmetic unit
// - a syllable issues only when its class environment is present, else it faults
// - descriptor bit one is the read-fault flag, bit two the write-fault flag
// - flagged level-1 fetch or store calls the matching named fault procedure
// - object codes: program 10, data 01, locked data 11, descriptor 00
// - data descriptors carry the value-stack-resident flag
// - three-bit format selector; zero means the most recently defined format
// - program descriptors carry parameters-present and result-returned flags
// - link length code picks a 4, 8, 12 or 16 bit lexical link
// - fault procedure names follow the attributes only when flagged, then expressions
// - structure field opens with a param width code and an allocate flag
// - segment-number expression always has a fixed 8-bit resource stack index
// - call expression carries a name; the closing expression is the end delimiter
// - coroutine names walk coroutine display, display, then slice entry
// - display names pick a display entry by depth, then a slice entry by displacement
// - slice names index the top slice; top-of-stack names pick the top entry
// - program names are program-base relative, n-base names name-stack-base relative
// - a clear allocate flag stops evaluation and raises the allocate fault
localparam int SDN_WORD_W = 64;
localparam int SDN_POS_W = 7;
localparam int SDN_ADDR_W = 8;
localparam int SDN_DATA_W = 32;
localparam logic [1:0] SDN_CLS_LIT = 2'h0;
localparam logic [1:0] SDN_CLS_AU = 2'h1;
localparam logic [1:0] SDN_CLS_NAME = 2'h2;
localparam logic [1:0] SDN_CLS_GEN = 2'h3;
localparam logic [1:0] SDN_OBJ_DESC = 2'h0;
localparam logic [1:0] SDN_OBJ_DATA = 2'h1;
localparam logic [1:0] SDN_OBJ_PROG = 2'h2;
localparam logic [1:0] SDN_OBJ_LOCK = 2'h3;
localparam logic [3:0] SDN_NT_COR88 = 4'h0;
localparam logic [3:0] SDN_NT_COR412 = 4'h1;
localparam logic [3:0] SDN_NT_DSP88 = 4'h2;
localparam logic [3:0] SDN_NT_DSP412 = 4'h3;
localparam logic [3:0] SDN_NT_SLC8 = 4'h4;
localparam logic [3:0] SDN_NT_SLC12 = 4'h5;
localparam logic [3:0] SDN_NT_PRG8 = 4'h6;
localparam logic [3:0] SDN_NT_PRG16 = 4'h7;
localparam logic [3:0] SDN_NT_NB8 = 4'h8;
localparam logic [3:0] SDN_NT_NB16 = 4'h9;
localparam logic [3:0] SDN_NT_CNB8 = 4'hA;
localparam logic [3:0] SDN_NT_CNB16 = 4'hB;
localparam logic [3:0] SDN_NT_TOP = 4'hC;
localparam logic [3:0] SDN_SE_FIN = 4'h0;
localparam logic [3:0] SDN_SE_SEG = 4'h1;
localparam logic [3:0] SDN_SE_CALL = 4'h2;
localparam logic [6:0] SDN_OPC_W = 7'h08;
localparam logic [6:0] SDN_LITHDR_W = 7'h0C;
localparam logic [6:0] SDN_IA_DESC_W = 7'h04;
localparam logic [6:0] SDN_IA_DATA_W = 7'h08;
localparam logic [6:0] SDN_SEHDR_W = 7'h08;
localparam logic [SDN_ADDR_W-1:0] SDN_R_CTRL = 8'h00;
localparam logic [SDN_ADDR_W-1:0] SDN_R_DISP_BASE = 8'h04;
localparam logic [SDN_ADDR_W-1:0] SDN_R_SLICE_BASE = 8'h08;
localparam logic [SDN_ADDR_W-1:0] SDN_R_PROG_BASE = 8'h0C;
localparam logic [SDN_ADDR_W-1:0] SDN_R_NBASE = 8'h10;
localparam logic [SDN_ADDR_W-1:0] SDN_R_TOP_ENTRY = 8'h14;
localparam logic [SDN_ADDR_W-1:0] SDN_R_STATUS = 8'h18;
localparam logic [SDN_ADDR_W-1:0] SDN_R_TERM_REF = 8'h1C;
localparam logic [SDN_ADDR_W-1:0] SDN_R_TBL_ADDR = 8'h20;
localparam logic [SDN_ADDR_W-1:0] SDN_R_COR_DATA = 8'h24;
localparam logic [SDN_ADDR_W-1:0] SDN_R_DISP_DATA = 8'h28;
localparam logic [SDN_DATA_W-1:0] SDN_CTRL_RST = 32'h00000001;
localparam logic [2:0] SDN_FMT_RST = 3'h1;
localparam int SDN_ST_ENV = 0;
localparam int SDN_ST_ALLOC = 1;
localparam int SDN_ST_INVALID = 2;
localparam int SDN_ST_BUSY = 3;
typedef enum logic [3:0] {
	SDN_IDLE = 4'b0001,
	SDN_COR = 4'b0010,
	SDN_DISP = 4'b0100,
	SDN_DONE = 4'b1000
} sdn_walk_e;
typedef struct packed {
	logic [7:0] opcode;
	logic [1:0] cls;
	logic [5:0] lit_len;
	logic lit_dest;
	logic [2:0] lit_fmt;
	logic [31:0] literal;
	logic [5:0] op_field;
	logic top_slice;
} sdn_syl_s;
typedef struct packed {
	logic [3:0] ntype;
	logic [3:0] coroutine_index;
	logic [7:0] lexical_depth;
	logic [15:0] disp;
	logic [4:0] len;
	logic invalid;
} sdn_name_s;
typedef struct packed {
	logic rd_flt;
	logic wr_flt;
	logic [1:0] obj;
	logic value_stack_resident_flag;
	logic [2:0] fmt_sel;
	logic params_present;
	logic result_returned;
	logic [15:0] display_ctl_word_idx;
	logic [2:0] param_width_code;
	logic alloc;
	logic [3:0] se_type;
	logic [15:0] se_param;
	logic end_delimiter;
} sdn_desc_s;
endpackage

// File: sim/sdn_pbuf_model.sv
module sdn_pbuf_model (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic ld,
	input wire logic [127:0] ld_words,
	input wire logic [sdn_pkg::SDN_POS_W-1:0] ld_pos,
	input wire logic syl_ready,
	output logic [sdn_pkg::SDN_WORD_W-1:0] prog_word_hi,
	output logic [sdn_pkg::SDN_WORD_W-1:0] prog_word_lo,
	output logic [sdn_pkg::SDN_POS_W-1:0] bit_pos,
	output logic syl_valid
);
	import sdn_pkg::*;
	initial {prog_word_hi, prog_word_lo, bit_pos, syl_valid} = '0;
	// a consumed syllable is inverted so stale words never pass for fresh ones
	always @(posedge clk_sys) begin
		if (rst) begin
			syl_valid <= 1'b0;
		end else if (ld) begin
			syl_valid <= 1'b1;
			{prog_word_hi, prog_word_lo} <= ld_words;
			bit_pos <= ld_pos;
		end else if (syl_valid && syl_ready) begin
			syl_valid <= 1'b0;
			{prog_word_hi, prog_word_lo} <= ~{prog_word_hi, prog_word_lo};
			bit_pos <= ~bit_pos;
		end
	end
endmodule // sdn_pbuf_model

// File: sim/sdn_decode_tb_top.sv
module sdn_decode_tb_top;
	timeunit 1ns;
	timeprecision 100ps;
	import sdn_pkg::*;
	logic clk_sys = 1'b0, rst = 1'b1, ce = 1'b1, reg_we = 1'b0, reg_re = 1'b0, ld = 1'b0, desc_valid = 1'b0;
	logic fetch_l1 = 1'b0, store_l1 = 1'b0, re_d = 1'b0;
	logic [7:0] reg_addr = '0;
	logic [31:0] reg_wdata = '0, rng = 32'h19B9BD6F;
	logic [127:0] ld_words = '0;
	logic [6:0] ld_pos = '0, bit_pos;
	logic [3:0] env_present = 4'hF;
	logic [63:0] desc_word = '0, prog_word_hi, prog_word_lo;
	logic syl_valid, syl_ready, syl_valid_o, lit_vs_push, lit_ns_push, au_valid, env_fault, term_valid;
	logic desc_valid_o, rd_fault_call, wr_fault_call, alloc_fault, invalid_field;
	logic [31:0] reg_rdata, term_ref;
	logic [5:0] au_op;
	logic [2:0] fmt_eff;
	sdn_syl_s syl_o;
	sdn_name_s name_o, rd_fault_name, wr_fault_name, call_name;
	sdn_desc_s desc_o;
	logic [35:0] notes[$];
	int miscompares = 0, checks_done = 0, cycles = 0;
	sdn_decode dut_u (.clk_sys, .rst, .ce, .reg_addr, .reg_wdata, .reg_we, .reg_re, .reg_rdata,
		.prog_word_hi, .prog_word_lo, .bit_pos, .syl_valid, .env_present, .syl_ready, .syl_o, .syl_valid_o,
		.lit_vs_push, .lit_ns_push, .name_o, .au_valid, .au_op, .env_fault, .term_ref, .term_valid,
		.desc_word, .desc_valid, .desc_o, .desc_valid_o, .fmt_eff, .rd_fault_name, .wr_fault_name,
		.call_name, .fetch_l1, .store_l1, .rd_fault_call, .wr_fault_call, .alloc_fault, .invalid_field);
	sdn_pbuf_model pbuf_u (.clk_sys, .rst, .ld, .ld_words, .ld_pos, .syl_ready, .prog_word_hi,
		.prog_word_lo, .bit_pos, .syl_valid);
	always #5 clk_sys = ~clk_sys;
	function automatic logic [31:0] rnd();
		rng ^= rng << 13;
		rng ^= rng >> 17;
		rng ^= rng << 5;
		return rng;
	endfunction
	task automatic report_and_stop();
		if (miscompares == 0 && checks_done > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	task automatic note(input logic [3:0] k, input logic [31:0] v);
		notes.push_back({k, v});
	endtask
	task automatic see(input logic [3:0] k, input logic [31:0] v);
		logic [35:0] e;
		checks_done++;
		e = (notes.size() == 0) ? '1 : notes.pop_front();
		if (e !== {k, v}) begin
			miscompares++;
			$display("CHECK FAILED event exp %h seen %h", e, {k, v});
		end
	endtask
	// results are matched in order of appearance, so a missing pulse shifts every later note
	always @(posedge clk_sys) begin
		re_d <= reg_re;
		cycles <= cycles + 1;
		if (cycles > 20000) begin
			miscompares++;
			report_and_stop();
		end
	end
	always @(negedge clk_sys) if (rst === 1'b0) begin
		if (syl_valid_o === 1'b1) see(1, {lit_vs_push, lit_ns_push, syl_o.cls, syl_o.opcode,
			(syl_o.cls === SDN_CLS_LIT) ? syl_o.literal[19:0] :
			(syl_o.cls === SDN_CLS_NAME) ? {name_o.ntype, name_o.disp} : 20'h0});
		if (au_valid === 1'b1) see(2, {26'h0, au_op});
		if (env_fault === 1'b1) see(3, 32'h0);
		if (term_valid === 1'b1) see(4, term_ref);
		if (desc_valid_o === 1'b1) see(5, {7'h0, call_name.ntype, rd_fault_name.ntype, wr_fault_name.ntype,
			desc_o.rd_flt, desc_o.wr_flt, desc_o.obj, desc_o.obj[0] ? {desc_o.value_stack_resident_flag,
			desc_o.fmt_sel} : {desc_o.params_present, desc_o.result_returned, 2'b00}, desc_o.alloc,
			desc_o.end_delimiter, fmt_eff});
		if (alloc_fault === 1'b1) see(6, 32'h0);
		if (rd_fault_call === 1'b1) see(7, 32'h0);
		if (wr_fault_call === 1'b1) see(8, 32'h0);
		if (invalid_field === 1'b1) see(9, 32'h0);
		if (re_d === 1'b1) see(10, reg_rdata);
	end
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_we <= 1'b1;
		@(posedge clk_sys);
		reg_we <= 1'b0;
		@(posedge clk_sys);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		note(10, e);
		reg_addr <= a;
		reg_re <= 1'b1;
		@(posedge clk_sys);
		reg_re <= 1'b0;
		@(posedge clk_sys);
	endtask
	task automatic issue(input logic [63:0] al, input logic [6:0] p);
		int i;
		ld_words <= ({al, 64'h0} >> p) | ({rnd(), rnd(), rnd(), rnd()} & ~({128{1'b1}} >> p));
		ld_pos <= p;
		ld <= 1'b1;
		@(posedge clk_sys);
		ld <= 1'b0;
		for (i = 0; i < 50; i++) begin
			@(posedge clk_sys);
			if (syl_valid === 1'b1 && syl_ready === 1'b1) break;
		end
		if (i == 50) begin
			miscompares++;
			$display("CHECK FAILED syllable take exp 1 seen 0");
		end
	endtask
	task automatic dsc(input logic [63:0] w);
		desc_word <= w;
		desc_valid <= 1'b1;
		@(posedge clk_sys);
		desc_valid <= 1'b0;
		desc_word <= ~w;
		@(posedge clk_sys);
	endtask
	initial begin
		int i;
		logic [31:0] r, b, v;
		logic [63:0] al;
		logic [5:0] w;
		logic [2:0] f, fe;
		logic [3:0] nt[4];
		logic [7:0] ra[4];
		logic [1:0] ob[4];
		nt = '{SDN_NT_SLC8, SDN_NT_PRG8, SDN_NT_NB8, SDN_NT_TOP};
		ra = '{SDN_R_SLICE_BASE, SDN_R_PROG_BASE, SDN_R_NBASE, SDN_R_TOP_ENTRY};
		ob = '{SDN_OBJ_DESC, SDN_OBJ_PROG, SDN_OBJ_DATA, SDN_OBJ_LOCK};
		fe = SDN_FMT_RST;
		repeat (6) @(posedge clk_sys);
		rst <= 1'b0;
		repeat (2) @(posedge clk_sys);
		rd(SDN_R_CTRL, SDN_CTRL_RST);
		rd(8'hFC, 32'h0);
		for (i = 0; i < 4; i++) begin
			r = rnd();
			al = {r, rnd()};
			al[63:60] = {2'b00, 2'(i)};
			w = 6'd4 << i;
			note(1, {~al[55], al[55], SDN_CLS_LIT, al[63:56], 20'(al[51:20] >> (32 - w))});
			issue(al, 7'(r[5:0]));
		end
		r = rnd();
		al = {2'b01, r[5:0], 56'h0};
		note(1, {2'b00, SDN_CLS_AU, al[63:56], 20'h0});
		note(2, {26'h0, r[5:0]});
		issue(al, 7'd0);
		al[63:62] = 2'b11;
		note(1, {2'b00, SDN_CLS_GEN, al[63:56], 20'h0});
		issue(al, 7'd9);
		env_present <= 4'hD;
		al[63:62] = 2'b01;
		note(3, 32'h0);
		issue(al, 7'd3);
		env_present <= 4'hF;
		@(posedge clk_sys);
		rd(SDN_R_STATUS, 32'h1);
		wr(SDN_R_STATUS, 32'h1);
		rd(SDN_R_STATUS, 32'h0);
		for (i = 0; i < 5; i++) begin
			b = rnd();
			r = rnd();
			wr(ra[i % 4], b);
			// the last pass sets the top-slice bit, so the displacement follows the opcode
			al = (i == 4) ? {2'b10, 6'h07, r[7:0], 48'h0} : {2'b10, 6'h0, nt[i], r[7:0], 44'h0};
			note(1, {2'b00, SDN_CLS_NAME, al[63:56], (i < 3) ? {nt[i], 8'h00, r[7:0]} : {SDN_NT_TOP, 16'h0}});
			note(4, (i == 3) ? b : b + r[7:0]);
			issue(al, 7'(r[13:8]));
		end
		b = rnd();
		r = rnd();
		v = rnd();
		wr(SDN_R_DISP_BASE, b);
		wr(SDN_R_TBL_ADDR, {24'h0, 8'(b + r[7:0])});
		wr(SDN_R_DISP_DATA, v);
		wr(SDN_R_COR_DATA, b);
		// second pass reaches the same slice entry through the coroutine table
		for (i = 0; i < 2; i++) begin
			al = {2'b10, 6'h0, SDN_NT_DSP88, r[7:0], r[15:8], 36'h0};
			if (i == 1) al[55:32] = {SDN_NT_COR88, 4'(b + r[7:0]), r[7:0], r[15:8]};
			note(1, {2'b00, SDN_CLS_NAME, al[63:56], al[55:52], 8'h00, r[15:8]});
			note(4, v + r[15:8]);
			issue(al, 7'(i * 9));
		end
		al = {2'b10, 6'h0, 4'hD, 52'h0};
		note(1, {2'b00, SDN_CLS_NAME, al[63:56], 4'hD, 16'h0});
		note(9, 32'h0);
		issue(al, 7'd5);
		for (i = 0; i < 4; i++) begin
			r = rnd();
			f = (i == 2) ? (r[2:0] | 3'h1) : 3'h0;
			al = {2'b00, ob[i], 60'h0};
			if (ob[i][0]) al[59:48] = {i == 2, f, 8'h10};
			else if (ob[i] == SDN_OBJ_PROG) al[59:48] = 12'hC01;
			else al[59:52] = 8'h10;
			if (i == 2) fe = f;
			note(5, {19'h0, 2'b00, ob[i], ob[i][0] ? {i == 2, f} : {ob[i][1], ob[i][1], 2'b00}, 2'b11,
				ob[i][0] ? fe : al[58:56]});
			dsc(al);
		end
		note(5, {7'h0, SDN_NT_TOP, 8'h00, 2'b00, SDN_OBJ_DESC, 4'h0, 2'b10, 3'h1});
		dsc({2'b00, SDN_OBJ_DESC, 8'h12, SDN_NT_TOP, 48'h0});
		note(6, 32'h0);
		dsc(64'h1000000000000000);
		al = {2'b11, SDN_OBJ_DATA, 4'h0, SDN_NT_TOP, SDN_NT_TOP, 8'h10, 40'h0};
		note(5, {11'h0, SDN_NT_TOP, SDN_NT_TOP, 2'b11, SDN_OBJ_DATA, 4'h0, 2'b11, fe});
		dsc(al);
		note(7, 32'h0);
		fetch_l1 <= 1'b1;
		@(posedge clk_sys);
		fetch_l1 <= 1'b0;
		note(8, 32'h0);
		store_l1 <= 1'b1;
		@(posedge clk_sys);
		store_l1 <= 1'b0;
		repeat (10) @(posedge clk_sys);
		// enable low: a flagged fetch and a read must both leave the outputs frozen
		ce <= 1'b0;
		fetch_l1 <= 1'b1;
		rd(SDN_R_CTRL, 32'h0);
		ce <= 1'b1;
		fetch_l1 <= 1'b0;
		checks_done++;
		if (notes.size() != 0) begin
			miscompares++;
			$display("CHECK FAILED pending exp 0 seen %0d", notes.size());
		end
		report_and_stop();
	end
endmodule // sdn_decode_tb_top
